// ### shared/dmfs_pkg.sv
// Constants and types for the demultiplexer frame synchronizer
package dmfs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] DMFS_OFS_CTRL = 4'h0;
  localparam logic [3:0] DMFS_OFS_STATUS = 4'h4;
  localparam logic [3:0] DMFS_OFS_ERRCNT = 4'h8;

  // ==========================================================
  // Field positions
  localparam int DMFS_CTRL_WLEN_LSB = 0;
  localparam int DMFS_ST_IN_FRAME = 0;
  localparam int DMFS_ST_LOF = 1;
  localparam int DMFS_ST_PSYNC_LSB = 2;
  localparam int DMFS_ST_CONF_LSB = 5;
  localparam int DMFS_ST_POS = 8;
  localparam int DMFS_ST_NEG = 9;
  localparam int DMFS_ERR_POS_LSB = 0;
  localparam int DMFS_ERR_NEG_LSB = 8;
  localparam int DMFS_ERR_NOACT_LSB = 16;

  // ==========================================================
  // Word length: n+1 bits, n from 15 to 31
  localparam logic [4:0] DMFS_WLEN_MIN = 5'h0F;
  localparam logic [4:0] DMFS_WLEN_RESET = 5'h1F;
  localparam int DMFS_DELAY_WORDS = 10;
  localparam int DMFS_STORE_BITS = 320;

  // ==========================================================
  // Minor frame timing
  localparam logic [5:0] DMFS_FRAME_WORDS = 6'h20;
  localparam logic [5:0] DMFS_ACQ_WORD = 6'h0B;
  localparam logic [5:0] DMFS_CHECK_FIRST = 6'h0C;
  localparam logic [5:0] DMFS_CHECK_LAST = 6'h17;
  localparam logic [5:0] DMFS_WORD_28 = 6'h1C;
  localparam logic [5:0] DMFS_WORD_29 = 6'h1D;

  // ==========================================================
  // Counter limits
  localparam logic [2:0] DMFS_CONF_LOAD = 3'h5;
  localparam logic [2:0] DMFS_CONF_UP_MAX = 3'h4;
  localparam logic [4:0] DMFS_ERR_LIMIT = 5'h08;
  localparam logic [4:0] DMFS_SERIAL_LIMIT = 5'h03;
  localparam logic [4:0] DMFS_ERR_SAT = 5'h1F;

  // ==========================================================
  // Stuff command codes, bit 22 is bit 0 of word 1
  localparam int DMFS_POS = 0;
  localparam int DMFS_NEG = 1;
  localparam int DMFS_NOACT = 2;
  localparam logic [22:0] DMFS_CODE_POS = 23'h4B5E27;
  localparam logic [22:0] DMFS_CODE_NEG = 23'h34A1D8;
  localparam logic [22:0] DMFS_CODE_NOACT = 23'h6C3391;

  typedef enum logic [1:0] {
    DMFS_ST_PARALLEL,
    DMFS_ST_SERIAL,
    DMFS_ST_FRAMED
  } dmfs_state_t;

endpackage

// ### verilog/dmfs_top.sv
// Frame synchronizer and stuff command decoder for the demultiplexer
// ==========================================================
//
// The implementer's own choices: the register offsets and strobed register access.
module dmfs_top
  import dmfs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link from the remote multiplexer
  input wire logic line_timing,
  input wire logic serial_in_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Frame status
  output logic in_frame,
  output logic loss_of_frame,
  output logic frame_sync_pulse_n,
  output logic word_28_strobe,
  output logic word_29_strobe,
  // Stuff command decode
  output logic pos_stuff_enable,
  output logic neg_stuff_enable,
  // Channel data
  output logic [3:0] chan_data_out
);

  // ==========================================================
  // Functions
  function automatic logic [8:0] tap_index(input logic [3:0] words, input logic [4:0] n);
    logic [5:0] primary;
    logic [5:0] odd_bit;
    logic [9:0] span;
    primary = n[0] ? 6'(n) + 6'h01 : 6'(n);
    odd_bit = n[0] ? 6'h00 : 6'h01;
    span = 10'(words) * 10'(primary + odd_bit);
    return 9'(span - 10'h001);
  endfunction

  function automatic logic code_bit(input logic [22:0] code, input logic [5:0] word);
    logic [4:0] idx;
    idx = 5'(6'h17 - word);
    return code[idx];
  endfunction

  function automatic logic [4:0] err_step(input logic [4:0] cnt, input logic miss);
    return (miss && cnt != DMFS_ERR_SAT) ? cnt + 5'h01 : cnt;
  endfunction

  // ==========================================================
  // Link input synchronizers
  logic [2:0] timing_sync;
  logic [2:0] data_sync;
  logic timing_level;
  logic data_level;
  wire timing_agree = timing_sync[1] == timing_sync[2];
  wire data_agree = data_sync[1] == data_sync[2];
  wire bit_tick = timing_agree && timing_sync[2] && !timing_level;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timing_sync <= 3'h0;
      data_sync <= 3'h7;
      timing_level <= 1'b0;
      data_level <= 1'b1;
    end else begin
      timing_sync <= {timing_sync[1:0], line_timing};
      data_sync <= {data_sync[1:0], serial_in_n};
      if (timing_agree) begin
        timing_level <= timing_sync[2];
      end
      if (data_agree) begin
        data_level <= data_sync[2];
      end
    end
  end

  // ==========================================================
  // Registers and state
  logic [4:0] word_n;
  logic [DMFS_STORE_BITS-1:0] word_delay_store;
  logic [4:0] bit_cnt;
  logic [5:0] word_cnt;
  dmfs_state_t state;
  logic [2:0] cmp_en;
  logic [2:0] psync;
  logic [4:0] err [3];
  logic [2:0] conf;

  // ==========================================================
  // Decoding
  wire live_bit_n = data_level;
  wire live = !live_bit_n;
  wire is_bit0 = bit_cnt == 5'h00;
  wire word_end = bit_cnt == word_n;
  wire w28 = bit_tick && is_bit0 && word_cnt == DMFS_WORD_28;
  wire w29 = bit_tick && is_bit0 && word_cnt == DMFS_WORD_29;
  wire in_check_words = word_cnt >= DMFS_CHECK_FIRST && word_cnt <= DMFS_CHECK_LAST;
  wire in_maint_words = word_cnt >= 6'h01 && word_cnt <= DMFS_CHECK_LAST;
  wire parallel_sync_enable = |psync;
  wire pos_code_enable = psync[DMFS_POS];
  wire neg_code_enable = psync[DMFS_NEG];
  wire noact_code_enable = psync[DMFS_NOACT];
  wire [2:0] serial_sel = {noact_code_enable, neg_code_enable, pos_code_enable};

  // Eleven samples: index 0 live, index d delayed d words
  logic [10:0] sample;
  assign sample[0] = live;
  for (genvar g = 1; g <= DMFS_DELAY_WORDS; g++) begin : g_tap
    assign sample[g] = word_delay_store[tap_index(4'(g), word_n)];
  end

  wire [2:0] match = {
    sample == DMFS_CODE_NOACT[22:12],
    sample == DMFS_CODE_NEG[22:12],
    sample == DMFS_CODE_POS[22:12]
  };

  wire search_on = state == DMFS_ST_PARALLEL && !in_frame && !parallel_sync_enable;
  wire acquire = bit_tick && search_on && |match;

  wire [2:0] miss = {
    live != code_bit(DMFS_CODE_NOACT, word_cnt),
    live != code_bit(DMFS_CODE_NEG, word_cnt),
    live != code_bit(DMFS_CODE_POS, word_cnt)
  };
  wire check_serial = state == DMFS_ST_SERIAL && in_check_words;
  wire check_maint = state == DMFS_ST_FRAMED && in_maint_words;
  wire count_err = bit_tick && is_bit0 && (check_serial || check_maint);

  wire [2:0] err_low = {
    err[DMFS_NOACT] < DMFS_ERR_LIMIT,
    err[DMFS_NEG] < DMFS_ERR_LIMIT,
    err[DMFS_POS] < DMFS_ERR_LIMIT
  };
  wire count_up = |err_low;
  wire count_down = &(~err_low);
  wire do_up = count_up && conf >= 3'h1 && conf <= DMFS_CONF_UP_MAX;
  wire do_down = count_down && conf >= 3'h1 && conf <= DMFS_CONF_LOAD;
  wire [2:0] next_conf = do_up ? conf + 3'h1 : (do_down ? conf - 3'h1 : conf);

  wire [4:0] sel_err = serial_sel[DMFS_POS] ? err[DMFS_POS]
                     : (serial_sel[DMFS_NEG] ? err[DMFS_NEG] : err[DMFS_NOACT]);
  // Masked during the sync pulse, while counts left from a failed try are cleared
  wire error_reset = state == DMFS_ST_SERIAL && frame_sync_pulse_n
                   && sel_err >= DMFS_SERIAL_LIMIT;

  wire [5:0] next_word = word_cnt == DMFS_FRAME_WORDS ? 6'h01 : word_cnt + 6'h01;
  wire [4:0] wr_wlen = wr_data[DMFS_CTRL_WLEN_LSB +: 5];
  wire [4:0] next_word_n = wr_wlen < DMFS_WLEN_MIN ? DMFS_WLEN_MIN : wr_wlen;

  // ==========================================================
  // Control register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_n <= DMFS_WLEN_RESET;
    end else if (wr_en && addr == DMFS_OFS_CTRL) begin
      word_n <= next_word_n;
    end
  end

  // ==========================================================
  // Delay store and word timing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_delay_store <= '0;
      bit_cnt <= 5'h00;
      word_cnt <= 6'h01;
    end else if (bit_tick) begin
      word_delay_store <= {word_delay_store[DMFS_STORE_BITS-2:0], live};
      if (acquire) begin
        bit_cnt <= 5'h01;
        word_cnt <= DMFS_ACQ_WORD;
      end else if (word_end) begin
        bit_cnt <= 5'h00;
        word_cnt <= next_word;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // ==========================================================
  // Acquisition latches and sync pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmp_en <= 3'h0;
      psync <= 3'h0;
      frame_sync_pulse_n <= 1'b1;
    end else begin
      cmp_en <= acquire ? match : 3'h0;
      frame_sync_pulse_n <= !(|cmp_en);
      if (|cmp_en) begin
        psync <= cmp_en;
      end else if (error_reset || w28 || state != DMFS_ST_SERIAL) begin
        psync <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Sync state and confidence counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= DMFS_ST_PARALLEL;
      in_frame <= 1'b0;
      loss_of_frame <= 1'b0;
      conf <= 3'h0;
    end else begin
      case (state)
        DMFS_ST_PARALLEL: begin
          if (|cmp_en) begin
            state <= DMFS_ST_SERIAL;
          end
        end
        DMFS_ST_SERIAL: begin
          if (error_reset) begin
            state <= DMFS_ST_PARALLEL;
          end else if (w28) begin
            state <= DMFS_ST_FRAMED;
            in_frame <= 1'b1;
            loss_of_frame <= 1'b0;
            conf <= DMFS_CONF_LOAD;
          end
        end
        DMFS_ST_FRAMED: begin
          if (w28) begin
            conf <= next_conf;
            if (next_conf == 3'h0) begin
              state <= DMFS_ST_PARALLEL;
              in_frame <= 1'b0;
              loss_of_frame <= 1'b1;
            end
          end
        end
        default: begin
          state <= DMFS_ST_PARALLEL;
        end
      endcase
    end
  end

  // ==========================================================
  // Bit error counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int c = 0; c < 3; c++) begin
        err[c] <= 5'h00;
      end
    end else if (!frame_sync_pulse_n || w29) begin
      for (int c = 0; c < 3; c++) begin
        err[c] <= 5'h00;
      end
    end else if (count_err) begin
      for (int c = 0; c < 3; c++) begin
        err[c] <= err_step(err[c], miss[c]);
      end
    end
  end

  // ==========================================================
  // Stuff decode, strobes and channel data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_stuff_enable <= 1'b0;
      neg_stuff_enable <= 1'b0;
      word_28_strobe <= 1'b0;
      word_29_strobe <= 1'b0;
      chan_data_out <= 4'h0;
    end else begin
      word_28_strobe <= w28;
      word_29_strobe <= w29;
      if (w28) begin
        pos_stuff_enable <= in_frame && err_low[DMFS_POS];
        neg_stuff_enable <= in_frame && err_low[DMFS_NEG];
      end else if (w29) begin
        pos_stuff_enable <= 1'b0;
        neg_stuff_enable <= 1'b0;
      end
      if (!in_frame) begin
        chan_data_out <= 4'h0;
      end else if (bit_tick) begin
        chan_data_out <= {4{live}};
      end
    end
  end

  // ==========================================================
  // Register read
  logic [31:0] status_word;
  logic [31:0] err_word;
  always_comb begin
    status_word = 32'h0;
    status_word[DMFS_ST_IN_FRAME] = in_frame;
    status_word[DMFS_ST_LOF] = loss_of_frame;
    status_word[DMFS_ST_PSYNC_LSB +: 3] = psync;
    status_word[DMFS_ST_CONF_LSB +: 3] = conf;
    status_word[DMFS_ST_POS] = pos_stuff_enable;
    status_word[DMFS_ST_NEG] = neg_stuff_enable;
    err_word = 32'h0;
    err_word[DMFS_ERR_POS_LSB +: 5] = err[DMFS_POS];
    err_word[DMFS_ERR_NEG_LSB +: 5] = err[DMFS_NEG];
    err_word[DMFS_ERR_NOACT_LSB +: 5] = err[DMFS_NOACT];
  end

  wire [31:0] read_mux = addr == DMFS_OFS_CTRL ? {27'h0, word_n}
                       : addr == DMFS_OFS_STATUS ? status_word
                       : addr == DMFS_OFS_ERRCNT ? err_word : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= rd_en ? read_mux : 32'h0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_sync_pulse_width: assert property (
    !frame_sync_pulse_n |=> frame_sync_pulse_n)
    else $error("sync pulse longer than one clock");
  a_sync_pulse_cause: assert property (
    acquire |=> ##1 !frame_sync_pulse_n)
    else $error("match gave no sync pulse");
  a_conf_ceiling: assert property (
    conf <= DMFS_CONF_LOAD)
    else $error("confidence above five");
  a_conf_load_five: assert property (
    $rose(in_frame) |-> conf == DMFS_CONF_LOAD)
    else $error("confidence not five at acquisition");
  a_lof_on_drop: assert property (
    $fell(in_frame) |-> loss_of_frame && conf == 3'h0)
    else $error("in-frame dropped without loss of frame");
  a_chan_inhibit: assert property (
    !in_frame |=> chan_data_out == 4'h0)
    else $error("channel data driven out of frame");
  a_err_clear_w29: assert property (
    w29 |=> err[DMFS_POS] == 5'h00 && err[DMFS_NEG] == 5'h00 && err[DMFS_NOACT] == 5'h00)
    else $error("error counters not cleared at word 29");
  a_no_acq_framed: assert property (
    in_frame |-> cmp_en == 3'h0)
    else $error("compare latch set while in frame");
  a_conf_step_down: assert property (
    w28 && in_frame && count_down && conf > 3'h1 |=> conf == $past(conf) - 3'h1)
    else $error("confidence did not step down");
  a_noact_both_low: assert property (
    w28 && !err_low[DMFS_POS] && !err_low[DMFS_NEG] |=> !pos_stuff_enable && !neg_stuff_enable)
    else $error("stuff enable raised on no-action code");
  a_serial_retry: assert property (
    error_reset |=> psync == 3'h0 && state == DMFS_ST_PARALLEL)
    else $error("error reset did not clear parallel sync");

endmodule

// ### tb/dmfs_mux_model.sv
// Behavioural remote multiplexer sending framed serial data
module dmfs_mux_model
  import dmfs_pkg::*;
(
  // Stream setup, taken at each frame start
  input wire logic [1:0] code_sel,
  input wire logic [4:0] wlen,
  input wire logic [4:0] err_first,
  input wire logic [4:0] err_num,
  input wire logic blank,
  // Line
  output logic line_timing,
  output logic serial_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Frame generator
  logic [22:0] code;
  logic [4:0] n;
  logic [4:0] e_lo;
  logic [4:0] e_num;
  logic blk;
  logic bit_val;
  initial begin
    line_timing = 1'b0;
    serial_in_n = 1'b1;
    forever begin
      n = wlen;
      e_lo = err_first;
      e_num = err_num;
      blk = blank;
      code = (code_sel == 2'h0) ? DMFS_CODE_POS :
        (code_sel == 2'h1) ? DMFS_CODE_NEG : DMFS_CODE_NOACT;
      for (int w = 1; w <= int'(DMFS_FRAME_WORDS); w++) begin
        for (int b = 0; b <= int'(n); b++) begin
          bit_val = 1'b1;
          // Code in bit 0 of words 1 to 23, optional errors
          if (b == 0 && w <= 23 && !blk) begin
            bit_val = code[23 - w] ^ (w >= e_lo && w < e_lo + e_num);
          end
          // Data changes just after the falling timing edge
          serial_in_n = ~bit_val;
          #200;
          line_timing = 1'b1;
          #200;
          line_timing = 1'b0;
        end
      end
    end
  end
endmodule

// ### tb/dmfs_top_tb_top.sv
// Self-checking bench for the frame synchronizer
module dmfs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dmfs_pkg::*;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [1:0] code_sel = 2'h0;
  logic [4:0] wlen = 5'h0F;
  logic [4:0] err_first = 5'h0C;
  logic [4:0] err_num = 5'h00;
  logic blank = 1'b0;
  wire logic line_timing, serial_in_n, in_frame, loss_of_frame, frame_sync_pulse_n;
  wire logic word_28_strobe, word_29_strobe, pos_stuff_enable, neg_stuff_enable;
  wire logic [31:0] rd_data;
  wire logic [3:0] chan_data_out;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] got;
  always #25 mclk = ~mclk;
  dmfs_top dut (.mclk(mclk), .rst_n(rst_n), .line_timing(line_timing),
    .serial_in_n(serial_in_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .in_frame(in_frame), .loss_of_frame(loss_of_frame),
    .frame_sync_pulse_n(frame_sync_pulse_n), .word_28_strobe(word_28_strobe),
    .word_29_strobe(word_29_strobe), .pos_stuff_enable(pos_stuff_enable),
    .neg_stuff_enable(neg_stuff_enable), .chan_data_out(chan_data_out));
  dmfs_mux_model mux (.code_sel(code_sel), .wlen(wlen), .err_first(err_first),
    .err_num(err_num), .blank(blank), .line_timing(line_timing),
    .serial_in_n(serial_in_n));
  // ==========================================================
  // Shared tasks
  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    got = rd_data;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Waits: 0 sync pulse, 1 in frame, 2 word 28, 3 word 29
  task automatic wait_on(input int which, input int limit);
    logic hit;
    for (int i = 0; i <= limit; i++) begin
      @(posedge mclk);
      #1;
      case (which)
        0: hit = (frame_sync_pulse_n === 1'b0);
        1: hit = (in_frame === 1'b1);
        2: hit = (word_28_strobe === 1'b1);
        default: hit = (word_29_strobe === 1'b1);
      endcase
      if (hit) begin
        return;
      end
    end
    bad_count++;
    $display("mismatch at %0t: got %h expected %h", $time, which, 1);
    conclude();
  endtask
  task automatic reset_dut(input logic [1:0] c, input logic [4:0] n, input logic [4:0] e);
    @(posedge mclk);
    rst_n <= 1'b0;
    code_sel <= c;
    err_num <= e;
    blank <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    wr(DMFS_OFS_CTRL, {27'h0, n});
    wlen <= n;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset();
    #1;
    check(32'({in_frame, loss_of_frame, frame_sync_pulse_n, word_28_strobe, word_29_strobe,
      pos_stuff_enable, neg_stuff_enable, chan_data_out}), 32'h100);
    rd(DMFS_OFS_STATUS);
    check(got, 32'h0);
    rd(DMFS_OFS_ERRCNT);
    check(got, 32'h0);
    rd(DMFS_OFS_CTRL);
    check(got, 32'h1F);
    cycles(1);
    check(rd_data, 32'h0);
    wr(DMFS_OFS_CTRL, 32'h05);
    rd(DMFS_OFS_CTRL);
    check(got, 32'h0F);
    wr(DMFS_OFS_STATUS, 32'hFFFF);
    rd(DMFS_OFS_STATUS);
    check(got, 32'h0);
    rd(4'hC);
    check(got, 32'h0);
  endtask
  task automatic s_code(input logic [1:0] c, input logic [4:0] n, input logic [4:0] e,
    input logic [1:0] en);
    reset_dut(c, n, e);
    wait_on(0, 9000);
    cycles(1);
    check(32'(frame_sync_pulse_n), 32'h1);
    rd(DMFS_OFS_STATUS);
    check(got & 32'h1C, 32'h04 << c);
    rd(DMFS_OFS_ERRCNT);
    check(got, 32'h0);
    wait_on(1, 5000);
    rd(DMFS_OFS_STATUS);
    check(got & 32'hFF, 32'hA1);
    cycles(20);
    check(32'(chan_data_out), 32'hF);
    wait_on(3, 5000);
    wait_on(2, 5000);
    cycles(2);
    check(32'({pos_stuff_enable, neg_stuff_enable}), 32'(en));
  endtask
  task automatic s_lof();
    logic [2:0] conf_exp [8] = '{3'h4, 3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    logic [7:0] bl_pat = 8'hF9;
    logic [31:0] err_exp;
    err_exp = 32'h1007 | (32'($countones(DMFS_CODE_POS ^ 23'h000FE0 ^ DMFS_CODE_NOACT)) << 16);
    for (int f = 0; f < 8; f++) begin
      @(posedge mclk);
      blank <= bl_pat[f];
      err_num <= (f == 1) ? 5'h07 : 5'h00;
      wait_on(2, 5000);
      cycles(2);
      rd(DMFS_OFS_STATUS);
      check(got & 32'hE0, {24'h0, conf_exp[f], 5'h00});
      if (f == 1) begin
        rd(DMFS_OFS_ERRCNT);
        check(got, err_exp);
        wait_on(3, 5000);
        cycles(2);
        rd(DMFS_OFS_ERRCNT);
        check(got, 32'h0);
      end
    end
    check(got & 32'h03, 32'h02);
    check(32'(chan_data_out), 32'h0);
    @(posedge mclk);
    blank <= 1'b0;
    wait_on(1, 12000);
    rd(DMFS_OFS_STATUS);
    check(got & 32'h03, 32'h01);
  endtask
  task automatic s_fail();
    reset_dut(2'h0, 5'h0F, 5'h03);
    wait_on(0, 9000);
    cycles(600);
    rd(DMFS_OFS_STATUS);
    check(got & 32'h1F, 32'h0);
    err_num <= 5'h00;
    wait_on(1, 12000);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset();
    s_code(2'h0, 5'h0F, 5'h02, 2'b10);
    s_lof();
    s_fail();
    s_code(2'h1, 5'h0F, 5'h00, 2'b01);
    s_code(2'h2, 5'h10, 5'h00, 2'b00);
    conclude();
  end
endmodule
